// File: printer_line_buffer_channel.sv
// Printer control unit front end: channel handshake, unpacker, line buffer.
// Assumes channel pins are asynchronous; printer handshakes are on clk_sys.
`timescale 1ns/10ps
module printer_line_buffer_channel
  import printer_line_buffer_channel_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [29:0] out_data,
  input  wire logic        function_strobe,
  input  wire logic        data_strobe,
  input  wire logic        status_accept,
  input  wire logic        master_clear,
  input  wire logic        charset_62,
  input  wire logic        feed_done,
  input  wire logic        print_done,
  input  wire logic [7:0]  print_col,
  output logic             word_request,
  output logic             status_interrupt,
  output logic      [29:0] in_data,
  output logic             feed_step,
  output logic             print_start,
  output logic      [6:0]  print_char
);
  localparam int SW = `WORD_W + 5;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [SW-1:0] meta_q;
  logic [SW-1:0] sync_q;
  logic [SW-1:0] prev_q;

  // Data pins share the strobe delay so the word stays aligned
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= {charset_62, master_clear, status_accept, data_strobe, function_strobe, out_data};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  wire [29:0] word_s = sync_q[29:0];
  wire        fs_s   = sync_q[30];
  wire        ds_s   = sync_q[31];
  wire        sa_s   = sync_q[32];
  wire        mc_s   = sync_q[33];
  wire        c62_s  = sync_q[34];
  wire        fs_rise = fs_s & ~prev_q[30];
  wire        ds_rise = ds_s & ~prev_q[31];

  // ---------------------------------------------------------------
  // Control state
  // ---------------------------------------------------------------
  state_e      state_q, state_d;
  logic        req_q, req_d;
  logic        int_mode_q, int_mode_d;
  logic [5:0]  spacing_q, spacing_d;
  logic [5:0]  feed_cnt_q, feed_cnt_d;
  logic        feed_busy_q, feed_busy_d;
  logic        feed_step_q, feed_step_d;
  logic [7:0]  col_q, col_d;
  logic [2:0]  sub_q, sub_d;
  logic [4:0]  rxw_q, rxw_d;
  logic        stop_q, stop_d;
  logic        term_q, term_d;
  logic        term_int_q, term_int_d;
  logic        stat_q, stat_d;
  logic [29:0] in_data_q, in_data_d;
  logic        print_start_q;
  logic [6:0]  print_char_q;
  logic        pop;
  logic        we;
  logic [6:0]  wdata;

  // ---------------------------------------------------------------
  // Channel decode and word request
  // ---------------------------------------------------------------
  wire [5:0]  op       = word_s[`OP_HI:`OP_LO];
  wire [5:0]  spacing  = word_s[`SP_HI:`SP_LO];
  wire        is_print = (op == `OP_PRINT_INT) | (op == `OP_PRINT);
  wire        is_term  = (op == `OP_TERM_INT) | (op == `OP_TERM);
  wire        fifo_in_ready;
  wire        fifo_valid;
  wire [29:0] fifo_word;
  wire        line_closed = (rxw_q == `WORDS_PER_LINE) | stop_q | term_q;
  wire        data_phase  = (state_q == ST_SPACE) | (state_q == ST_LOAD);
  // A state about to close the line must not raise a one-cycle request
  wire        next_takes  = (state_d == ST_IDLE) | (state_d == ST_SPACE) | (state_d == ST_LOAD);
  wire        can_take    = next_takes & ((state_q == ST_IDLE) | (data_phase & fifo_in_ready & ~line_closed));
  wire        fn_take     = fs_rise & req_q;
  wire        dt_take     = ds_rise & req_q & data_phase;

  // Drop on acceptance; return only after the strobe is withdrawn
  assign req_d = (fn_take | dt_take) ? 1'b0 :
                 ~can_take           ? 1'b0 :
                 (~fs_s & ~ds_s)     ? 1'b1 : req_q;

  // ---------------------------------------------------------------
  // Unpacker: most significant group first
  // ---------------------------------------------------------------
  wire [4:0]  shamt   = 5'(sub_q) * 5'd6;
  wire [29:0] shifted = fifo_word << shamt;
  wire [5:0]  chr     = shifted[29:24];
  wire        is_stop = c62_s & (chr == `CODE_STOP);
  wire        blank   = (chr == `CODE_BLANK);
  wire        at_last = (col_q == `LB_LAST);

  // ---------------------------------------------------------------
  // Sequencer next state
  // ---------------------------------------------------------------
  always_comb begin
    state_d     = state_q;
    int_mode_d  = int_mode_q;
    spacing_d   = spacing_q;
    feed_cnt_d  = feed_cnt_q;
    feed_busy_d = feed_busy_q;
    feed_step_d = 1'b0;
    col_d       = col_q;
    sub_d       = sub_q;
    rxw_d       = dt_take ? rxw_q + 5'd1 : rxw_q;
    stop_d      = stop_q;
    term_d      = term_q;
    term_int_d  = term_int_q;
    stat_d      = stat_q;
    in_data_d   = in_data_q;
    pop         = 1'b0;
    we          = 1'b0;
    wdata       = {1'b0, chr};
    // A terminate is latched when taken during spacing or loading
    if (fn_take & is_term & data_phase) begin
      term_d     = 1'b1;
      term_int_d = (op == `OP_TERM_INT);
    end
    case (state_q)
      ST_IDLE: begin
        if (fn_take & is_print) begin
          int_mode_d  = (op == `OP_PRINT_INT);
          spacing_d   = spacing;
          feed_cnt_d  = '0;
          feed_busy_d = 1'b0;
          col_d       = '0;
          sub_d       = '0;
          rxw_d       = '0;
          stop_d      = 1'b0;
          term_d      = 1'b0;
          state_d     = ST_SPACE;
        end else if (fn_take & (op == `OP_TERM_INT)) begin
          state_d = ST_STATUS;
        end
      end
      ST_SPACE: begin
        // One line per step, handshaked with the paper transport
        if (feed_cnt_q == spacing_q) begin
          state_d = ST_LOAD;
        end else if (!feed_busy_q) begin
          feed_step_d = 1'b1;
          feed_busy_d = 1'b1;
        end else if (feed_done) begin
          feed_busy_d = 1'b0;
          feed_cnt_d  = feed_cnt_q + 6'd1;
        end
      end
      ST_LOAD: begin
        if (fifo_valid) begin
          we    = 1'b1;
          wdata = is_stop ? `CODE_FILL : {1'b0, chr};
          col_d = col_q + 8'd1;
          sub_d = sub_q + 3'd1;
          if (at_last) begin
            pop     = 1'b1;
            state_d = ST_PRINT;
          end else if (is_stop) begin
            pop     = 1'b1;
            stop_d  = 1'b1;
            state_d = ST_FILL;
          end else if (sub_q == `LAST_SUB) begin
            pop   = 1'b1;
            sub_d = '0;
          end
        end else if (term_q) begin
          // Early end; with no data the line is simply dropped
          state_d = (col_q != 8'h00) ? ST_FILL :
                    term_int_q       ? ST_STATUS : ST_IDLE;
        end
      end
      ST_FILL: begin
        we      = 1'b1;
        wdata   = `CODE_FILL;
        col_d   = col_q + 8'd1;
        state_d = at_last ? ST_PRINT : ST_FILL;
      end
      ST_PRINT: begin
        if (print_done) begin
          col_d   = '0;
          sub_d   = '0;
          rxw_d   = '0;
          stop_d  = 1'b0;
          if (term_q) begin
            state_d = term_int_q ? ST_STATUS : ST_IDLE;
          end else if (int_mode_q) begin
            state_d = ST_STATUS;
          end else begin
            // Spacing is retained for every line of the run; the step count restarts
            feed_cnt_d = '0;
            state_d    = ST_SPACE;
          end
        end
      end
      ST_STATUS: begin
        stat_d    = 1'b1;
        in_data_d = {`STATUS_NORMAL, 24'h000000};
        if (stat_q & sa_s) begin
          stat_d  = 1'b0;
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // Sequencer registers; master clear acts like reset
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {req_q, int_mode_q, feed_busy_q, feed_step_q, stop_q, term_q, term_int_q, stat_q} <= '0;
      {spacing_q, feed_cnt_q, col_q, sub_q, rxw_q, in_data_q} <= '0;
      state_q <= ST_IDLE;
    end else if (mc_s) begin
      {req_q, int_mode_q, feed_busy_q, feed_step_q, stop_q, term_q, term_int_q, stat_q} <= '0;
      {spacing_q, feed_cnt_q, col_q, sub_q, rxw_q, in_data_q} <= '0;
      state_q <= ST_IDLE;
    end else begin
      {req_q, int_mode_q, feed_busy_q, feed_step_q} <= {req_d, int_mode_d, feed_busy_d, feed_step_d};
      {stop_q, term_q, term_int_q, stat_q} <= {stop_d, term_d, term_int_d, stat_d};
      {spacing_q, feed_cnt_q, col_q, sub_q, rxw_q} <= {spacing_d, feed_cnt_d, col_d, sub_d, rxw_d};
      in_data_q <= in_data_d;
      state_q   <= state_d;
    end
  end

  // Word FIFO; leftover words are dropped when a line closes
  line_fifo #(.WIDTH(`WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .clr       (mc_s | (state_q == ST_FILL) | (state_q == ST_PRINT)),
    .in_valid  (dt_take),
    .in_ready  (fifo_in_ready),
    .in_data   (word_s),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_word)
  );

  // ---------------------------------------------------------------
  // Line buffer, random access read by the print mechanism
  // ---------------------------------------------------------------
  logic [6:0] line_mem [0:`LB_COLS-1];

  always_ff @(posedge clk_sys) begin
    if (we) begin
      line_mem[col_q] <= wdata;
    end
  end

  // Read data registered; out-of-range columns read as zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      print_char_q  <= '0;
      print_start_q <= 1'b0;
    end else begin
      print_char_q  <= (print_col < `LB_COLS) ? line_mem[print_col] : 7'h00;
      print_start_q <= (state_d == ST_PRINT) & ~mc_s;
    end
  end

  assign word_request     = req_q;
  assign status_interrupt = stat_q;
  assign in_data          = in_data_q;
  assign feed_step        = feed_step_q;
  assign print_start      = print_start_q;
  assign print_char       = print_char_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_take;
    (fn_take | dt_take) && !mc_s;
  endsequence
  property p_req_drop;
    s_take |=> !word_request;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("request held after accept");
  property p_req_ok;
    word_request |-> (state_q == ST_IDLE) || (data_phase && !line_closed);
  endproperty
  a_req_ok: assert property (p_req_ok) else $error("request while busy");
  property p_feed_max;
    feed_step |-> feed_cnt_q < spacing_q && spacing_q <= `MAX_FEED;
  endproperty
  a_feed_max: assert property (p_feed_max) else $error("extra paper step");
  property p_col_max;
    we |-> col_q <= `LB_LAST;
  endproperty
  a_col_max: assert property (p_col_max) else $error("write beyond line");
  sequence s_stop;
    state_q == ST_LOAD && fifo_valid && is_stop && !at_last && !mc_s;
  endsequence
  // The stop column itself is filled in LOAD; the next column follows in FILL
  sequence s_fill_step;
    state_q == ST_FILL && we && wdata == `CODE_FILL;
  endsequence
  property p_stop_fill;
    s_stop |=> s_fill_step;
  endproperty
  a_stop_fill: assert property (p_stop_fill) else $error("stop code did not fill");
  property p_fill_code;
    state_q == ST_FILL |-> we && wdata == `CODE_FILL;
  endproperty
  a_fill_code: assert property (p_fill_code) else $error("fill code wrong");
  // Blank code is stored unchanged for the print side to space over
  property p_blank;
    state_q == ST_LOAD && we && blank |-> wdata == {1'b0, `CODE_BLANK};
  endproperty
  a_blank: assert property (p_blank) else $error("blank code altered");
  property p_full_line;
    state_q == ST_LOAD && state_d == ST_PRINT && !mc_s |-> at_last && rxw_q == `WORDS_PER_LINE;
  endproperty
  a_full_line: assert property (p_full_line) else $error("short line printed");
  property p_order;
    state_q == ST_LOAD && fifo_valid && !at_last && !is_stop && !mc_s |=> col_q == $past(col_q) + 8'd1;
  endproperty
  a_order: assert property (p_order) else $error("column not ascending");
  property p_status;
    status_interrupt && !sa_s && !mc_s |=> status_interrupt && $stable(in_data);
  endproperty
  a_status: assert property (p_status) else $error("status word dropped");
  property p_clear;
    mc_s |=> state_q == ST_IDLE && !word_request && !status_interrupt;
  endproperty
  a_clear: assert property (p_clear) else $error("master clear ignored");
endmodule : printer_line_buffer_channel

// File: printer_line_buffer_channel_map.svh
// Constants of the printer line buffer channel: field positions, codes, counts.
// Assumes a single 100 MHz system clock domain; included by package and modules.
`ifndef PRINTER_LINE_BUFFER_CHANNEL_MAP_SVH
`define PRINTER_LINE_BUFFER_CHANNEL_MAP_SVH

`define WORD_W         30
`define CHAR_W         6
`define OP_HI          29
`define OP_LO          24
`define SP_HI          23
`define SP_LO          18
`define LB_COLS        8'h84
`define LB_LAST        8'h83
`define WORDS_PER_LINE 5'h1B
`define LAST_SUB       3'h4
`define CODE_BLANK     6'h05
`define CODE_STOP      6'h3F
`define CODE_FILL      7'h40
`define OP_PRINT_INT   6'h0A
`define OP_PRINT       6'h02
`define OP_TERM_INT    6'h1B
`define OP_TERM        6'h13
`define STATUS_NORMAL  6'h20
`define MAX_FEED       6'h3F

`endif

// File: printer_line_buffer_channel_pkg.sv
// Types shared by the printer line buffer channel.
// Assumes the constants header is on the include path.
package printer_line_buffer_channel_pkg;
  `include "printer_line_buffer_channel_map.svh"

  // Control sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SPACE,
    ST_LOAD,
    ST_FILL,
    ST_PRINT,
    ST_STATUS
  } state_e;
endpackage : printer_line_buffer_channel_pkg

// File: line_fifo.sv
// Word FIFO between the channel data strobe and the character unpacker.
// Assumes both sides share clk_sys; DEPTH is a power of two.
`timescale 1ns/10ps
module line_fifo #(
  parameter int WIDTH = 30,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             clr,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              push;
  wire              pop;

  // ---------------------------------------------------------------
  // Handshake
  // ---------------------------------------------------------------
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_q];

  // Storage has no reset; only pointers and fill count carry state
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // Pointers and fill count; clr drops queued words
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (clr) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= push ? wr_q + 1'b1 : wr_q;
      rd_q  <= pop ? rd_q + 1'b1 : rd_q;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : line_fifo

// File: proc_channel_model.sv
// Processor channel model: sends function and data words, takes status words.
// Assumes the device samples the channel on clk_sys; this side drives at falling edges.
`timescale 1ns/10ps
module proc_channel_model (
  input  wire logic        clk_sys,
  input  wire logic        word_request,
  input  wire logic        status_interrupt,
  input  wire logic [29:0] in_data,
  output logic      [29:0] out_data,
  output logic             function_strobe,
  output logic             data_strobe,
  output logic             status_accept
);
  // -----------------------------------------------------------------
  // Idle levels
  // -----------------------------------------------------------------
  initial begin
    out_data        = 30'h2AAAAAAA;
    function_strobe = 1'b0;
    data_strobe     = 1'b0;
    status_accept   = 1'b0;
  end

  // One word across the channel; held until the request drops
  task automatic send_word(input logic fn, input logic [29:0] w, output logic ok);
    int n;
    n = 0;
    while (word_request !== 1'b1 && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
    ok = (n < 3000);
    out_data = w;
    if (fn) begin
      function_strobe = 1'b1;
    end else begin
      data_strobe = 1'b1;
    end
    n = 0;
    while (word_request !== 1'b0 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    ok = ok && (n < 50);
    function_strobe = 1'b0;
    data_strobe     = 1'b0;
    out_data        = ~w; // Released lines must not keep the old word
  endtask : send_word

  // Status word: taken, then acknowledged until the interrupt drops
  task automatic take_status(output logic [29:0] s, output logic ok);
    int n;
    n = 0;
    while (status_interrupt !== 1'b1 && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
    ok = (n < 3000);
    s = in_data;
    status_accept = 1'b1;
    n = 0;
    while (status_interrupt !== 1'b0 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    ok = ok && (n < 50);
    status_accept = 1'b0;
  endtask : take_status
endmodule : proc_channel_model

// File: tb_top.sv
// Self-checking bench for the printer line buffer channel.
// Assumes the constants header is on the include path; printer side is stood in here.
`timescale 1ns/10ps
`include "printer_line_buffer_channel_map.svh"
`define CHK(got, exp, msg) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("CHECK FAILED t=%0t %s", $time, msg); \
    end \
  end
module tb_top;
  logic        clk_sys;
  logic        rst;
  logic        master_clear;
  logic        charset_62;
  logic        feed_done;
  logic        print_done;
  logic [7:0]  print_col;
  logic [29:0] out_data;
  logic [29:0] in_data;
  logic        function_strobe;
  logic        data_strobe;
  logic        status_accept;
  logic        word_request;
  logic        status_interrupt;
  logic        feed_step;
  logic        print_start;
  logic [6:0]  print_char;
  logic [6:0]  exp_line [132];
  logic [29:0] st;
  logic        ok;
  int          error_cnt;
  int          check_count;
  int          feed_cnt;
  int          feed_delay;

  // -----------------------------------------------------------------
  // Structure
  // -----------------------------------------------------------------
  printer_line_buffer_channel #(.FIFO_DEPTH(16)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .out_data(out_data), .function_strobe(function_strobe),
    .data_strobe(data_strobe), .status_accept(status_accept), .master_clear(master_clear),
    .charset_62(charset_62), .feed_done(feed_done), .print_done(print_done), .print_col(print_col),
    .word_request(word_request), .status_interrupt(status_interrupt), .in_data(in_data),
    .feed_step(feed_step), .print_start(print_start), .print_char(print_char)
  );
  proc_channel_model u_proc (
    .clk_sys(clk_sys), .word_request(word_request), .status_interrupt(status_interrupt),
    .in_data(in_data), .out_data(out_data), .function_strobe(function_strobe),
    .data_strobe(data_strobe), .status_accept(status_accept)
  );

  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;

  // Paper transport stand-in; a long delay stalls the unpacker so the FIFO fills
  initial begin
    feed_done = 1'b0;
    forever begin
      @(negedge clk_sys);
      if (feed_step === 1'b1) begin
        feed_cnt++;
        repeat (feed_delay) @(negedge clk_sys);
        feed_done = 1'b1;
        @(negedge clk_sys);
        feed_done = 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  function automatic logic [29:0] word_of(input int w);
    logic [29:0] r;
    for (int k = 0; k < 5; k++) r[29-6*k -: 6] = 6'(w * 5 + k);
    return r;
  endfunction : word_of

  task automatic wait_req;
    int n;
    n = 0;
    while (word_request !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK(word_request, 1'b1, "request did not return")
  endtask : wait_req

  task automatic wait_start;
    int n;
    n = 0;
    while (print_start !== 1'b1 && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK(print_start, 1'b1, "line never started printing")
  endtask : wait_start

  // Reads every column back through the print-side port
  task automatic check_line;
    for (int c = 0; c < 132; c++) begin
      print_col = 8'(c);
      @(negedge clk_sys);
      `CHK(print_char, exp_line[c], "line buffer column mismatch")
    end
  endtask : check_line

  task automatic pulse_done;
    print_done = 1'b1;
    @(negedge clk_sys);
    print_done = 1'b0;
  endtask : pulse_done

  task automatic send(input logic fn, input logic [29:0] w);
    u_proc.send_word(fn, w, ok);
    `CHK(ok, 1'b1, "word not taken")
  endtask : send

  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  // Full line of 27 words, FIFO driven full while paper is still moving
  task automatic t_full_line;
    charset_62 = 1'b0;
    feed_cnt   = 0;
    feed_delay = 600;
    send(1'b1, {`OP_PRINT_INT, 6'h02, 18'h2A5A5});
    for (int i = 0; i < 16; i++) send(1'b0, word_of(i));
    repeat (20) @(negedge clk_sys);
    `CHK(word_request, 1'b0, "full FIFO still requesting")
    for (int i = 16; i < 27; i++) send(1'b0, word_of(i));
    for (int c = 0; c < 132; c++) exp_line[c] = {1'b0, 6'(c)};
    wait_start();
    `CHK(feed_cnt, 2, "spacing count mismatch")
    `CHK(word_request, 1'b0, "request after last word")
    check_line();
    pulse_done();
    u_proc.take_status(st, ok);
    `CHK(st[29:24], `STATUS_NORMAL, "status code mismatch")
    `CHK(ok, 1'b1, "interrupt held after accept")
    wait_req();
    feed_delay = 3;
  endtask : t_full_line

  // Stop code ends the line; terminate without interrupt then idles
  task automatic t_stop;
    charset_62 = 1'b1;
    send(1'b1, {`OP_PRINT, 6'h00, 18'h00000});
    send(1'b0, {6'h11, `CODE_BLANK, `CODE_STOP, 6'h22, 6'h33});
    exp_line[0] = 7'h11;
    exp_line[1] = 7'h05;
    for (int c = 2; c < 132; c++) exp_line[c] = `CODE_FILL;
    wait_start();
    `CHK(word_request, 1'b0, "request after stop code")
    check_line();
    pulse_done();
    send(1'b1, {`OP_TERM, 6'h00, 18'h00000});
    wait_req();
    `CHK(status_interrupt, 1'b0, "interrupt without request")
  endtask : t_stop

  // Terminate with interrupt after two words closes a short line
  task automatic t_term;
    feed_cnt = 0;
    send(1'b1, {`OP_PRINT, 6'h01, 18'h3FFFF});
    send(1'b0, word_of(0));
    send(1'b0, word_of(1));
    send(1'b1, {`OP_TERM_INT, 6'h00, 18'h00000});
    for (int c = 0; c < 132; c++) exp_line[c] = (c < 10) ? {1'b0, 6'(c)} : `CODE_FILL;
    wait_start();
    `CHK(feed_cnt, 1, "spacing count mismatch")
    check_line();
    pulse_done();
    u_proc.take_status(st, ok);
    `CHK(st[29:24], `STATUS_NORMAL, "terminate status mismatch")
    `CHK(ok, 1'b1, "terminate status handshake")
    wait_req();
  endtask : t_term

  // Master clear abandons a half-loaded line
  task automatic t_clear;
    send(1'b1, {`OP_PRINT_INT, 6'h00, 18'h00000});
    send(1'b0, word_of(3));
    repeat (10) @(negedge clk_sys);
    master_clear = 1'b1;
    repeat (6) @(negedge clk_sys);
    `CHK(word_request, 1'b0, "request during clear")
    `CHK(print_start, 1'b0, "printing during clear")
    master_clear = 1'b0;
    wait_req();
    send(1'b1, {`OP_TERM_INT, 6'h00, 18'h00000});
    u_proc.take_status(st, ok);
    `CHK(st[29:24], `STATUS_NORMAL, "idle terminate status")
    `CHK(ok, 1'b1, "idle terminate handshake")
    `CHK(print_start, 1'b0, "abandoned line printed")
  endtask : t_clear

  // -----------------------------------------------------------------
  // Sequence, watchdog and verdict
  // -----------------------------------------------------------------
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  initial begin
    rst          = 1'b1;
    master_clear = 1'b0;
    charset_62   = 1'b0;
    print_done   = 1'b0;
    print_col    = 8'h00;
    feed_delay   = 3;
    repeat (16) @(negedge clk_sys);
    `CHK(word_request, 1'b0, "request during reset")
    `CHK(status_interrupt, 1'b0, "interrupt during reset")
    rst = 1'b0;
    wait_req();
    t_full_line();
    t_stop();
    t_term();
    t_clear();
    wrap_up();
  end

  // Whole run is a few thousand cycles; this is ten times that
  initial begin
    #300000;
    error_cnt++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    wrap_up();
  end
endmodule : tb_top
